/* File: design/slci_pkg.sv */
// Shared constants and types of the serial link configuration interpreter.
package slci_pkg;

    // Timing: clock, reply delay unit, uptime second and escape wait.
    localparam int CLK_PERIOD_NS = 5;
    localparam int DELAY_UNIT_NS = 4_000_000;
    localparam int DELAY_UNIT_CYC = DELAY_UNIT_NS / CLK_PERIOD_NS;
    localparam int SECOND_NS = 1_000_000_000;
    localparam int SECOND_CYC = SECOND_NS / CLK_PERIOD_NS;
    localparam int ESC_WAIT_S = 5;
    localparam int ESC_WAIT_CYC = ESC_WAIT_S * SECOND_CYC;

    // Parser geometry.
    localparam int KW_W = 64;
    localparam int NUM_W = 16;
    localparam int MAX_ARGS = 4;

    // Characters.
    localparam logic [7:0] CH_CR = 8'h0D;
    localparam logic [7:0] CH_LF = 8'h0A;
    localparam logic [7:0] CH_SPACE = 8'h20;
    localparam logic [7:0] CH_TAB = 8'h09;
    localparam logic [7:0] CH_COMMA = 8'h2C;
    localparam logic [7:0] CH_ZERO = 8'h30;
    localparam logic [7:0] CH_NINE = 8'h39;
    localparam logic [7:0] CH_LOW_A = 8'h61;
    localparam logic [7:0] CH_LOW_Z = 8'h7A;
    localparam logic [7:0] CASE_BIT = 8'h20;
    localparam logic [7:0] CH_N = 8'h4E;
    localparam logic [7:0] CH_E = 8'h45;
    localparam logic [7:0] CH_O = 8'h4F;
    localparam logic [7:0] CH_S = 8'h53;
    localparam logic [7:0] CH_R = 8'h52;
    localparam logic [7:0] CH_P = 8'h50;
    localparam logic [7:0] CH_M = 8'h4D;

    // Command words, upper case, right aligned.
    localparam logic [KW_W-1:0] KW_SERI = 64'h0000_0000_5345_5249;
    localparam logic [KW_W-1:0] KW_ADDR = 64'h0000_0000_4144_4452;
    localparam logic [KW_W-1:0] KW_SDELAY = 64'h0000_5344_454C_4159;
    localparam logic [KW_W-1:0] KW_OPEN = 64'h0000_0000_4F50_454E;
    localparam logic [KW_W-1:0] KW_CLOSE = 64'h0000_0043_4C4F_5345;
    localparam logic [KW_W-1:0] KW_TIME = 64'h0000_0000_5449_4D45;
    localparam logic [KW_W-1:0] KW_RESET = 64'h0000_0052_4553_4554;
    localparam logic [KW_W-1:0] KW_FACTORY = 64'h4652_4553_544F_5245;
    localparam logic [KW_W-1:0] KW_SMODE = 64'h0000_0053_4D4F_4445;
    localparam logic [KW_W-1:0] KW_SEND = 64'h0000_0000_5345_4E44;
    localparam logic [KW_W-1:0] KW_STOP_RUN = 64'h0000_0000_0000_0053;
    localparam logic [KW_W-1:0] KW_ESCAPE = 64'h0000_0000_0000_0023;

    // Framing encodings and factory values.
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [2:0] BAUD_DEF = 3'h6;
    localparam logic [1:0] PAR_DEF = PAR_NONE;
    localparam logic DATA8_DEF = 1'b1;
    localparam logic STOP2_DEF = 1'b0;
    localparam logic [7:0] NODE_DEF = 8'h00;
    localparam logic [7:0] SDELAY_DEF = 8'h0A;
    localparam logic [NUM_W-1:0] BYTE_MAX = 16'h00FF;
    localparam logic [NUM_W-1:0] NUM_SAT = 16'h1999;

    typedef enum logic [1:0] {
        MODE_STOP, MODE_RUN, MODE_POLL, MODE_FIELDBUS
    } slci_mode_t;
    localparam slci_mode_t MODE_DEF = MODE_STOP;

    typedef enum logic [3:0] {
        RPL_OK, RPL_ERR, RPL_SERI, RPL_ADDR, RPL_DELAY, RPL_OPEN,
        RPL_CLOSE, RPL_TIME, RPL_MODE, RPL_SEND, RPL_FIELDBUS
    } slci_reply_t;

    // Line speed to code 0..6 with a valid flag in bit 3.
    function automatic logic [3:0] slci_baud_code(input logic [15:0] v);
        case (v)
            16'h012C: slci_baud_code = 4'h8;
            16'h0258: slci_baud_code = 4'h9;
            16'h04B0: slci_baud_code = 4'hA;
            16'h0960: slci_baud_code = 4'hB;
            16'h12C0: slci_baud_code = 4'hC;
            16'h2580: slci_baud_code = 4'hD;
            16'h4B00: slci_baud_code = 4'hE;
            default: slci_baud_code = 4'h0;
        endcase
    endfunction

    function automatic logic [7:0] slci_upper(input logic [7:0] c);
        if (c >= CH_LOW_A && c <= CH_LOW_Z) begin
            slci_upper = c & ~CASE_BIT;
        end else begin
            slci_upper = c;
        end
    endfunction

endpackage

/* File: design/slci_line_parser.sv */
// Tokenises received characters into a command word and arguments.
`timescale 1ns/1ps
module slci_line_parser import slci_pkg::*; #(
    parameter int N_ARGS = MAX_ARGS
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    output logic line_valid,
    output logic [KW_W-1:0] line_kw,
    output logic [2:0] line_argc,
    output logic [N_ARGS*NUM_W-1:0] line_nums,
    output logic [N_ARGS*8-1:0] line_chrs,
    output logic [N_ARGS-1:0] line_bad
);
    logic [KW_W-1:0] kw_reg;
    logic [2:0] ntok_reg;
    logic in_tok_reg;
    logic [NUM_W-1:0] num_reg [0:N_ARGS-1];
    logic [7:0] chr_reg [0:N_ARGS-1];
    logic [N_ARGS-1:0] bad_reg;

    wire [7:0] ch_up = slci_upper(rx_byte);
    wire is_cr = rx_byte == CH_CR;
    wire is_sep = rx_byte == CH_SPACE || rx_byte == CH_TAB ||
        rx_byte == CH_COMMA || rx_byte == CH_LF;
    wire is_digit = rx_byte >= CH_ZERO && rx_byte <= CH_NINE;
    wire tok_start = !in_tok_reg && !is_sep && !is_cr;
    wire [2:0] tok_n = tok_start ? ntok_reg + 3'd1 : ntok_reg;
    wire [2:0] arg_i = tok_n - 3'd2;
    wire [2:0] argc_w = (ntok_reg == 3'd0) ? 3'd0 : ntok_reg - 3'd1;

    always_ff @(posedge clk) begin
        if (rst) begin
            kw_reg <= '0;
            ntok_reg <= '0;
            in_tok_reg <= 1'b0;
            bad_reg <= '0;
            for (int i = 0; i < N_ARGS; i++) begin
                num_reg[i] <= '0;
                chr_reg[i] <= '0;
            end
            line_valid <= 1'b0;
            line_kw <= '0;
            line_argc <= '0;
            line_nums <= '0;
            line_chrs <= '0;
            line_bad <= '0;
        end else begin
            line_valid <= 1'b0;
            if (rx_valid && is_cr) begin
                line_valid <= 1'b1;
                line_kw <= kw_reg;
                line_argc <= (argc_w > 3'(N_ARGS)) ? 3'(N_ARGS) : argc_w;
                line_bad <= bad_reg;
                for (int i = 0; i < N_ARGS; i++) begin
                    line_nums[i*NUM_W +: NUM_W] <= num_reg[i];
                    line_chrs[i*8 +: 8] <= chr_reg[i];
                    num_reg[i] <= '0;
                    chr_reg[i] <= '0;
                end
                kw_reg <= '0;
                ntok_reg <= '0;
                in_tok_reg <= 1'b0;
                bad_reg <= '0;
            end else if (rx_valid && is_sep) begin
                in_tok_reg <= 1'b0;
            end else if (rx_valid) begin
                in_tok_reg <= 1'b1;
                if (tok_n != 3'd7) begin
                    ntok_reg <= tok_n;
                end
                if (tok_n == 3'd1) begin
                    // Longer words lose their head; only their last eight characters are compared.
                    kw_reg <= {kw_reg[KW_W-9:0], ch_up};
                end
                for (int i = 0; i < N_ARGS; i++) begin
                    if (tok_n >= 3'd2 && arg_i == 3'(i)) begin
                        if (tok_start) begin
                            chr_reg[i] <= ch_up;
                        end
                        if (!is_digit || num_reg[i] > NUM_SAT) begin
                            bad_reg[i] <= 1'b1;
                        end else begin
                            num_reg[i] <= NUM_W'(num_reg[i] * 16'd10 +
                                {8'h00, rx_byte - CH_ZERO});
                        end
                    end
                end
            end
        end
    end
endmodule // slci_line_parser

/* File: design/slci_top.sv */
// Serial link command interpreter: settings, session, uptime and replies.
//
// Contract
// - New framing kept pending until next reset.
// - Only seven listed line speeds accepted.
// - Parity N/E/O, 7/8 data, 1/2 stop.
// - Default framing 19200, none, 8, 1.
// - Hold eight-bit node address 0 to 255.
// - Reply waits delay count times 4 ms.
// - Matching session-open enables all operator commands.
// - Session-close returns to addressed-only answering.
// - Count and report uptime since reset.
// - Reset command restarts, keeps settings, stored mode.
// - Factory command restores every user setting.
// - Fieldbus mode uses RTU framing both ways.
// - Register number equals address field plus one.
// - Fieldbus mode ignores text, only address writable.
// - Hash and CR after 5 s escapes fieldbus.
// - Escape lasts until next reset command, which restores fieldbus; power-up loads stop mode.
// - Address zero offline; 248 to 255 answered.
// - Fieldbus reply gets same 4 ms delay.
// - Fieldbus start-up mode active after restart.
// - Locked poll mode takes only send, open.
// - New start-up mode active after restart.
`timescale 1ns/1ps
module slci_top import slci_pkg::*; #(
    parameter int DELAY_CYCLES = DELAY_UNIT_CYC,
    parameter int SEC_CYCLES = SECOND_CYC,
    parameter int ESC_CYCLES = ESC_WAIT_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic rx_valid,
    input wire logic [7:0] rx_byte,
    input wire logic mb_req_valid,
    input wire logic [7:0] mb_req_node,
    input wire logic [15:0] mb_req_addr,
    input wire logic mb_addr_wr,
    input wire logic [7:0] mb_addr_data,
    output logic [2:0] link_baud,
    output logic [1:0] link_parity,
    output logic link_data8,
    output logic link_stop2,
    output logic [7:0] node_addr,
    output slci_mode_t link_mode,
    output logic fieldbus_active,
    output logic session_open,
    output logic [31:0] uptime_sec,
    output logic measure_send,
    output logic reply_valid,
    output slci_reply_t reply_code,
    output logic [31:0] reply_value
);
    logic p_valid;
    logic [KW_W-1:0] p_kw;
    logic [2:0] p_argc;
    logic [MAX_ARGS*NUM_W-1:0] p_nums;
    logic [MAX_ARGS*8-1:0] p_chrs;
    logic [MAX_ARGS-1:0] p_bad;

    slci_line_parser #(.N_ARGS(MAX_ARGS)) u_parser (
        .clk(clk),
        .rst(rst),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte),
        .line_valid(p_valid),
        .line_kw(p_kw),
        .line_argc(p_argc),
        .line_nums(p_nums),
        .line_chrs(p_chrs),
        .line_bad(p_bad)
    );

    logic [2:0] st_baud_reg;
    logic [1:0] st_par_reg;
    logic st_d8_reg;
    logic st_s2_reg;
    slci_mode_t st_mode_reg;
    logic [7:0] sdelay_reg;
    logic [31:0] sec_cnt_reg;
    logic [31:0] esc_cnt_reg;
    logic pend_reg;
    logic [7:0] dly_left_reg;
    logic [31:0] tick_reg;
    slci_reply_t pend_code_reg;
    logic [31:0] pend_value_reg;

    wire [15:0] a0_num = p_nums[15:0];
    wire [7:0] a1_chr = p_chrs[15:8];
    wire [15:0] a2_num = p_nums[47:32];
    wire [15:0] a3_num = p_nums[63:48];
    wire [7:0] a0_chr = p_chrs[7:0];
    wire a0_ok = p_argc != 3'd0 && !p_bad[0];
    wire a0_byte = a0_ok && a0_num <= BYTE_MAX;
    wire addr_match = a0_byte && a0_num[7:0] == node_addr;

    wire cmd_seri = p_kw == KW_SERI;
    wire cmd_addr = p_kw == KW_ADDR;
    wire cmd_sdelay = p_kw == KW_SDELAY;
    wire cmd_open = p_kw == KW_OPEN;
    wire cmd_close = p_kw == KW_CLOSE;
    wire cmd_time = p_kw == KW_TIME;
    wire cmd_reset = p_kw == KW_RESET;
    wire cmd_factory = p_kw == KW_FACTORY;
    wire cmd_smode = p_kw == KW_SMODE;
    wire cmd_send = p_kw == KW_SEND;

    wire is_fb = link_mode == MODE_FIELDBUS;
    wire is_run = link_mode == MODE_RUN;
    wire is_poll = link_mode == MODE_POLL;
    wire full_ok = p_valid && p_kw != '0 &&
        (link_mode == MODE_STOP || (is_poll && session_open));
    // locked poll accepts send and open
    wire open_hit = p_valid && cmd_open && addr_match && !is_fb && !is_run;
    wire send_hit = p_valid && cmd_send && !is_fb && !is_run &&
        (addr_match || (full_ok && p_argc == 3'd0));
    wire stop_hit = p_valid && is_run && p_kw == KW_STOP_RUN;
    // escape after the wait from restart
    wire esc_ready = esc_cnt_reg == 32'(ESC_CYCLES);
    wire esc_hit = p_valid && is_fb && p_kw == KW_ESCAPE && esc_ready;
    // address zero is offline, all others answer
    wire mb_hit = is_fb && mb_req_valid && node_addr != 8'h00 &&
        mb_req_node == node_addr;

    wire [3:0] bcode = slci_baud_code(a0_num);
    wire par_ok = a1_chr == CH_N || a1_chr == CH_E || a1_chr == CH_O;
    wire [1:0] par_val = (a1_chr == CH_E) ? PAR_EVEN :
        (a1_chr == CH_O) ? PAR_ODD : PAR_NONE;
    wire d_ok = !p_bad[2] && (a2_num == 16'h0007 || a2_num == 16'h0008);
    wire s_ok = !p_bad[3] && (a3_num == 16'h0001 || a3_num == 16'h0002);
    wire seri_ok = a0_ok && bcode[3] && (p_argc < 3'd2 || par_ok) &&
        (p_argc < 3'd3 || d_ok) && (p_argc < 3'd4 || s_ok);
    wire [2:0] n_baud = (p_argc >= 3'd1) ? bcode[2:0] : st_baud_reg;
    wire [1:0] n_par = (p_argc >= 3'd2) ? par_val : st_par_reg;
    wire n_d8 = (p_argc >= 3'd3) ? a2_num[3] : st_d8_reg;
    wire n_s2 = (p_argc >= 3'd4) ? a3_num[1] : st_s2_reg;
    wire seri_set = full_ok && cmd_seri && p_argc != 3'd0 && seri_ok;
    wire [31:0] seri_val = seri_set ?
        {25'h0, n_baud, n_par, n_d8, n_s2} :
        {25'h0, st_baud_reg, st_par_reg, st_d8_reg, st_s2_reg};

    wire mode_ok = a0_chr == CH_S || a0_chr == CH_R || a0_chr == CH_P ||
        a0_chr == CH_M;
    wire slci_mode_t mode_val = (a0_chr == CH_R) ? MODE_RUN :
        (a0_chr == CH_P) ? MODE_POLL :
        (a0_chr == CH_M) ? MODE_FIELDBUS : MODE_STOP;
    wire smode_set = full_ok && cmd_smode && p_argc != 3'd0 && mode_ok;
    wire addr_set = full_ok && cmd_addr && a0_byte;
    wire delay_set = full_ok && cmd_sdelay && a0_byte;
    wire close_hit = full_ok && cmd_close;
    wire reset_hit = full_ok && cmd_reset;
    wire factory_hit = full_ok && cmd_factory;

    logic rsp_fire;
    slci_reply_t rsp_code;
    logic [31:0] rsp_value;

    always_comb begin
        rsp_fire = 1'b0;
        rsp_code = RPL_ERR;
        rsp_value = '0;
        if (mb_hit) begin
            rsp_fire = 1'b1;
            rsp_code = RPL_FIELDBUS;
            rsp_value = {16'h0000, 16'(mb_req_addr + 16'h0001)};
        end else if (esc_hit || stop_hit) begin
            rsp_fire = 1'b1;
            rsp_code = RPL_OK;
        end else if (open_hit) begin
            rsp_fire = 1'b1;
            rsp_code = RPL_OPEN;
            rsp_value = {24'h0, node_addr};
        end else if (send_hit) begin
            rsp_fire = 1'b1;
            rsp_code = RPL_SEND;
            rsp_value = {24'h0, node_addr};
        end else if (full_ok && !reset_hit) begin
            rsp_fire = 1'b1;
            if (cmd_seri && (p_argc == 3'd0 || seri_ok)) begin
                rsp_code = RPL_SERI;
                rsp_value = seri_val;
            end else if (cmd_addr && (p_argc == 3'd0 || a0_byte)) begin
                rsp_code = RPL_ADDR;
                rsp_value = {24'h0, addr_set ? a0_num[7:0] : node_addr};
            end else if (cmd_sdelay && (p_argc == 3'd0 || a0_byte)) begin
                rsp_code = RPL_DELAY;
                rsp_value = {24'h0, delay_set ? a0_num[7:0] : sdelay_reg};
            end else if (cmd_smode && (p_argc == 3'd0 || mode_ok)) begin
                rsp_code = RPL_MODE;
                rsp_value = {30'h0, smode_set ? mode_val : st_mode_reg};
            end else if (cmd_close) begin
                rsp_code = RPL_CLOSE;
            end else if (cmd_time) begin
                rsp_code = RPL_TIME;
                rsp_value = uptime_sec;
            end else if (cmd_factory) begin
                rsp_code = RPL_OK;
            end
        end
    end

    // Stored settings; address and delay act at once, framing and mode wait.
    always_ff @(posedge clk) begin
        if (rst || factory_hit) begin
            st_baud_reg <= BAUD_DEF;
            st_par_reg <= PAR_DEF;
            st_d8_reg <= DATA8_DEF;
            st_s2_reg <= STOP2_DEF;
            st_mode_reg <= MODE_DEF;
            node_addr <= NODE_DEF;
            sdelay_reg <= SDELAY_DEF;
        end else begin
            if (seri_set) begin
                st_baud_reg <= n_baud;
                st_par_reg <= n_par;
                st_d8_reg <= n_d8;
                st_s2_reg <= n_s2;
            end
            if (smode_set) begin
                st_mode_reg <= mode_val;
            end
            // fieldbus may change only the address
            if (addr_set) begin
                node_addr <= a0_num[7:0];
            end else if (is_fb && mb_addr_wr) begin
                node_addr <= mb_addr_data;
            end
            if (delay_set) begin
                sdelay_reg <= a0_num[7:0];
            end
        end
    end

    // Link state. The reset command is a restart that keeps stored settings.
    always_ff @(posedge clk) begin
        if (rst) begin
            link_baud <= BAUD_DEF;
            link_parity <= PAR_DEF;
            link_data8 <= DATA8_DEF;
            link_stop2 <= STOP2_DEF;
            link_mode <= MODE_DEF;
            fieldbus_active <= 1'b0;
            session_open <= 1'b0;
            uptime_sec <= '0;
            sec_cnt_reg <= '0;
            esc_cnt_reg <= '0;
        end else if (reset_hit) begin
            link_baud <= st_baud_reg;
            link_parity <= st_par_reg;
            link_data8 <= st_d8_reg;
            link_stop2 <= st_s2_reg;
            link_mode <= st_mode_reg;
            fieldbus_active <= st_mode_reg == MODE_FIELDBUS;
            session_open <= 1'b0;
            uptime_sec <= '0;
            sec_cnt_reg <= '0;
            esc_cnt_reg <= '0;
        end else begin
            if (sec_cnt_reg == 32'(SEC_CYCLES - 1)) begin
                sec_cnt_reg <= '0;
                uptime_sec <= uptime_sec + 32'h0000_0001;
            end else begin
                sec_cnt_reg <= sec_cnt_reg + 32'h0000_0001;
            end
            if (!esc_ready) begin
                esc_cnt_reg <= esc_cnt_reg + 32'h0000_0001;
            end
            if (esc_hit || stop_hit) begin
                link_mode <= MODE_STOP;
                fieldbus_active <= 1'b0;
            end
            if (open_hit) begin
                session_open <= 1'b1;
            end else if (close_hit) begin
                session_open <= 1'b0;
            end
        end
    end

    // Replies wait sdelay units; a newer reply replaces an unsent one.
    always_ff @(posedge clk) begin
        if (rst || reset_hit) begin
            pend_reg <= 1'b0;
            dly_left_reg <= '0;
            tick_reg <= '0;
            pend_code_reg <= RPL_OK;
            pend_value_reg <= '0;
            reply_valid <= 1'b0;
            reply_code <= RPL_OK;
            reply_value <= '0;
            measure_send <= 1'b0;
        end else begin
            reply_valid <= 1'b0;
            measure_send <= send_hit && !mb_hit;
            if (rsp_fire) begin
                pend_reg <= 1'b1;
                dly_left_reg <= sdelay_reg;
                tick_reg <= '0;
                pend_code_reg <= rsp_code;
                pend_value_reg <= rsp_value;
            end else if (pend_reg && dly_left_reg == 8'h00) begin
                pend_reg <= 1'b0;
                reply_valid <= 1'b1;
                reply_code <= pend_code_reg;
                reply_value <= pend_value_reg;
            end else if (pend_reg) begin
                if (tick_reg == 32'(DELAY_CYCLES - 1)) begin
                    tick_reg <= '0;
                    dly_left_reg <= dly_left_reg - 8'h01;
                end else begin
                    tick_reg <= tick_reg + 32'h0000_0001;
                end
            end
        end
    end
endmodule // slci_top

/* File: tb/slci_host_model.sv */
// Host terminal model that types text lines into the receiver.
`timescale 1ns/1ps
module slci_host_model (
    input wire logic clk,
    output logic rx_valid,
    output logic [7:0] rx_byte
);
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
    end
    task automatic send_line(input string s);
        for (int i = 0; i <= s.len(); i++) begin
            @(posedge clk);
            rx_valid <= 1'b1;
            rx_byte <= (i == s.len()) ? 8'h0D : s[i];
        end
        @(posedge clk);
        rx_valid <= 1'b0;
        // An idle line must not keep showing the last character.
        rx_byte <= ~rx_byte;
    endtask
endmodule // slci_host_model

/* File: tb/slci_top_asserts.sv */
// Port checker of the serial link command interpreter.
`timescale 1ns/1ps
module slci_top_asserts import slci_pkg::*; #(
    parameter int SEC_CYCLES = 20
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic mb_req_valid,
    input wire logic [7:0] mb_req_node,
    input wire logic [2:0] link_baud,
    input wire logic [1:0] link_parity,
    input wire logic link_data8,
    input wire logic link_stop2,
    input wire logic [7:0] node_addr,
    input wire slci_mode_t link_mode,
    input wire logic fieldbus_active,
    input wire logic [31:0] uptime_sec,
    input wire logic reply_valid,
    input wire slci_reply_t reply_code
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [31:0] tick_cnt;
    wire logic [6:0] framing = {link_baud, link_parity, link_data8, link_stop2};
    always_ff @(posedge clk) begin
        tick_cnt <= (rst || $changed(uptime_sec)) ? 32'h0 : tick_cnt + 32'h1;
    end
    sequence s_fb_hit;
        fieldbus_active && mb_req_valid && mb_req_node == node_addr
            && node_addr != 8'h00;
    endsequence
    sequence s_fb_reply;
        reply_valid && reply_code == RPL_FIELDBUS;
    endsequence
    // Delay counts above 249 would outlast this bound, so it is a limit.
    chk_fb_answer: assert property (s_fb_hit |-> ##[2:1000] s_fb_reply)
        else $error("addressed fieldbus request unanswered");
    chk_reset_values: assert property ($fell(rst) |-> framing == 7'h62
        && node_addr == 8'h00 && link_mode == MODE_STOP)
        else $error("wrong values after reset");
    chk_reply_pulse: assert property (reply_valid |=> !reply_valid)
        else $error("reply strobe longer than one cycle");
    chk_second_tick: assert property (tick_cnt <= SEC_CYCLES)
        else $error("uptime seconds stalled");
    chk_uptime_step: assert property ($changed(uptime_sec) |->
        uptime_sec == 32'h0 || uptime_sec == $past(uptime_sec) + 32'h1)
        else $error("uptime jumped");
    chk_framing_hold: assert property ($changed(framing) |->
        uptime_sec == 32'h0) else $error("framing changed without restart");
    chk_mode_restart: assert property ($changed(link_mode)
        && link_mode != MODE_STOP |-> uptime_sec == 32'h0)
        else $error("mode entered without restart");
    chk_fb_flag: assert property (fieldbus_active ==
        (link_mode == MODE_FIELDBUS)) else $error("fieldbus flag wrong");
endmodule // slci_top_asserts

bind slci_top slci_top_asserts #(.SEC_CYCLES(SEC_CYCLES)) chk_inst (
    .clk, .rst, .mb_req_valid, .mb_req_node, .link_baud, .link_parity,
    .link_data8, .link_stop2, .node_addr, .link_mode, .fieldbus_active,
    .uptime_sec, .reply_valid, .reply_code);

/* File: tb/slci_top_tb.sv */
// Self-checking bench of the serial link command interpreter.
`timescale 1ns/1ps
`define CHK(n, g, e) begin compares++; if ((g) !== (e)) begin \
    bad_count++; $display("ERROR %s exp %0h got %0h", n, e, g); end end
module slci_top_tb import slci_pkg::*;;
    logic clk = 1'b0, rst = 1'b1, mb_req_valid = 1'b0, mb_addr_wr = 1'b0;
    logic rx_valid, link_data8, link_stop2, fieldbus_active;
    logic session_open, measure_send, reply_valid;
    logic [7:0] rx_byte, node_addr, mb_req_node = 8'h00;
    logic [15:0] mb_req_addr = 16'h0000;
    logic [2:0] link_baud;
    logic [1:0] link_parity;
    logic [31:0] uptime_sec, reply_value;
    slci_mode_t link_mode;
    slci_reply_t reply_code;
    int bad_count = 0, compares = 0, sends = 0;
    wire logic [6:0] framing = {link_baud, link_parity, link_data8, link_stop2};
    always #2.5 clk = ~clk;
    always @(posedge clk) if (measure_send === 1'b1) sends++;
    slci_host_model slci_host_model_inst (.clk, .rx_valid, .rx_byte);
    slci_top #(.DELAY_CYCLES(4), .SEC_CYCLES(20), .ESC_CYCLES(50))
        slci_top_inst (.clk, .rst, .rx_valid, .rx_byte, .mb_req_valid,
        .mb_req_node, .mb_req_addr, .mb_addr_wr, .mb_addr_data(mb_req_node),
        .link_baud, .link_parity, .link_data8, .link_stop2, .node_addr,
        .link_mode, .fieldbus_active, .session_open, .uptime_sec,
        .measure_send, .reply_valid, .reply_code, .reply_value);
    task automatic final_report();
        if (bad_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic wait_reply(output int n);
        for (n = 1; n <= 2000; n++) begin
            @(posedge clk);
            #1;
            if (reply_valid === 1'b1) return;
        end
        bad_count++;
        final_report();
    endtask
    task automatic cmd(string s, slci_reply_t c, int lat = 0);
        int n;
        if (s.len() > 0) slci_host_model_inst.send_line(s);
        wait_reply(n);
        `CHK(s, reply_code, c)
        if (lat > 0) `CHK("latency", n, lat)
    endtask
    task automatic quiet(string s);
        if (s.len() > 0) slci_host_model_inst.send_line(s);
        repeat (60) begin
            @(posedge clk);
            #1;
            `CHK("silence", reply_valid, 1'b0)
        end
    endtask
    task automatic send_wait(string s);
        slci_host_model_inst.send_line(s);
        repeat (4) @(posedge clk);
    endtask
    task automatic mb(logic wr, logic [7:0] nd, logic [15:0] ad);
        @(posedge clk);
        {mb_addr_wr, mb_req_valid, mb_req_node, mb_req_addr} <= {wr, !wr, nd, ad};
        @(posedge clk);
        {mb_addr_wr, mb_req_valid} <= 2'h0;
    endtask
    task automatic t_framing();
        int sp[7] = '{300, 600, 1200, 2400, 4800, 9600, 19200};
        `CHK("framing", framing, 7'h62)
        cmd("time", RPL_TIME, 42);
        foreach (sp[i]) begin
            cmd($sformatf("seri %0d", sp[i]), RPL_SERI);
            `CHK("speed", reply_value[6:4], 3'(i))
        end
        cmd("seri 1234", RPL_ERR);
        cmd("seri 9600 o 7 2", RPL_SERI);
        `CHK("odd", reply_value[3:0], 4'h9)
        cmd("seri 9600 e", RPL_SERI);
        `CHK("pending", framing, 7'h62)
        send_wait("reset");
        `CHK("applied", framing, 7'h55)
        cmd("sdelay 0", RPL_DELAY);
        cmd("time", RPL_TIME, 2);
        cmd("sdelay 2", RPL_DELAY);
        cmd("time", RPL_TIME, 10);
    endtask
    task automatic t_poll();
        send_wait("reset");
        repeat (70) @(posedge clk);
        `CHK("uptime", uptime_sec, 32'h0000_0003)
        `CHK("kept", framing, 7'h55)
        cmd("addr 7", RPL_ADDR);
        `CHK("node", node_addr, 8'h07)
        cmd("smode p", RPL_MODE);
        `CHK("stored", link_mode, MODE_STOP)
        send_wait("reset");
        `CHK("poll", link_mode, MODE_POLL)
        quiet("time");
        quiet("open 3");
        cmd("send 7", RPL_SEND);
        `CHK("send pulse", sends, 1)
        cmd("open 7", RPL_OPEN);
        `CHK("open", session_open, 1'b1)
        cmd("time", RPL_TIME);
        cmd("close", RPL_CLOSE);
        `CHK("closed", session_open, 1'b0)
        quiet("time");
    endtask
    task automatic t_fieldbus();
        cmd("open 7", RPL_OPEN);
        cmd("seri 19200 n 8 2", RPL_SERI);
        cmd("smode m", RPL_MODE);
        send_wait("reset");
        `CHK("fieldbus", fieldbus_active, 1'b1)
        quiet("#");
        quiet("addr 3");
        `CHK("node kept", node_addr, 8'h07)
        mb(1'b0, 8'h07, 16'h0004);
        cmd("", RPL_FIELDBUS);
        `CHK("register", reply_value, 32'h0000_0005)
        mb(1'b1, 8'h00, 16'h0000);
        mb(1'b0, 8'h00, 16'h0000);
        quiet("");
        mb(1'b1, 8'hFA, 16'h0000);
        mb(1'b0, 8'hFA, 16'h0009);
        cmd("", RPL_FIELDBUS);
        `CHK("high node", reply_value, 32'h0000_000A)
        send_wait("#");
        `CHK("escaped", link_mode, MODE_STOP)
        send_wait("reset");
        `CHK("again", fieldbus_active, 1'b1)
        repeat (60) @(posedge clk);
        send_wait("#");
        send_wait($sformatf("%s", KW_FACTORY));
        send_wait("reset");
        `CHK("factory", framing, 7'h62)
        `CHK("node", node_addr, 8'h00)
        `CHK("mode", link_mode, MODE_STOP)
        cmd("time", RPL_TIME, 42);
        cmd("smode r", RPL_MODE);
        send_wait("reset");
        `CHK("run", link_mode, MODE_RUN)
        quiet("time");
        cmd("s", RPL_OK);
        `CHK("stop", link_mode, MODE_STOP)
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_framing();
        t_poll();
        t_fieldbus();
        final_report();
    end
endmodule // slci_top_tb
